/* File: adcc_ctrl.sv */
`timescale 1ns/100ps
// Contract
// - Three-bit field selects buffer and input mode
// - Reference select split across two registers
// - Four-bit field selects analog input
// - Control 0 fields written together
// - Continuous bit repeats conversions
// - Writing conversion enable starts conversion
// - First result after 5129, plus 40
// - Enable bit cleared at first result
// - First result requests interrupt
// - Later results every 256 cycles
// - Thirteen-bit result split high/low registers
// - Every result requests interrupt
// - Disabled converter finishes the running conversion, raising one more request
// - Offset then gain; thirteen data bits
// - Overflow status bit for current sample
module adcc_ctrl
   import adcc_pkg::*;
#(
   parameter int FIRST_CYC  = FIRST_CONV_CYC,   // First conversion cycles
   parameter int PWR_CYC    = PWRUP_CYC,        // Power-up cycles
   parameter int REP_CYC    = REPEAT_CYC        // Repeat cycles
) (
   input  logic              clk,
   input  logic              reset,
   // AXI4-Lite slave
   input  logic [7:0]        s_axi_awaddr,
   input  logic              s_axi_awvalid,
   output logic              s_axi_awready,
   input  logic [31:0]       s_axi_wdata,
   input  logic [3:0]        s_axi_wstrb,
   input  logic              s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  logic              s_axi_bready,
   input  logic [7:0]        s_axi_araddr,
   input  logic              s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  logic              s_axi_rready,
   // Analog core side
   input  logic [RES_W-1:0]  coreResult,
   input  logic              coreOverflow,
   output logic [3:0]        inputChannelSelect,
   output logic [2:0]        inputBufferSelect,
   output logic [1:0]        vrefLevelSel,
   output logic              vrefPinOutput,
   output logic              corePowerOn,
   output logic              sampleStrobe,
   // Interrupt controller request
   output logic              convDoneIrq
);

   // Counter sized from the sum of all three phases, so no phase count wraps
   // Sum of all three phases is a safe upper bound for any one of them
   localparam int CW = $clog2(FIRST_CYC + PWR_CYC + REP_CYC + 1);  // Cycle counter width

   adcc_state_t      state;                      // Sequencer state
   logic [CW-1:0]    cycleCnt;                   // Cycles left in phase
   logic             repeatConvert;              // Continuous bit
   logic             convertGo;                  // Conversion enable bit
   logic [7:0]       resultUpperByte;            // Data high register
   logic [4:0]       resultLowerBits;            // Data low register bits
   logic             sampleOverflowFlag;         // Overflow status
   logic             awHeld;                     // Write address latched
   logic             wHeld;                      // Write data latched
   logic [7:0]       awAddr;                     // Latched write address
   logic [31:0]      wData;                      // Latched write data
   logic [3:0]       wStrb;                      // Latched strobes
   logic             doWrite;                    // Write commits this cycle
   logic             ctl0Write;                  // Control 0 byte written
   logic             phaseEnd;                   // Count reached zero
   logic             resultDone;                 // A conversion completes

   assign doWrite    = awHeld && wHeld && !s_axi_bvalid;
   assign ctl0Write  = doWrite && awAddr == ADCC_CTL0_OFS && wStrb[0];
   assign phaseEnd   = cycleCnt == '0;
   assign resultDone = phaseEnd && (state == ST_FIRST || state == ST_REPEAT);

   // Write address and data accepted in either order
   always_ff @(posedge clk) begin
      if (reset) begin
         awHeld <= 1'b0;
         wHeld  <= 1'b0;
         awAddr <= 8'h00;
         wData  <= 32'h0;
         wStrb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld <= 1'b0;
         end
      end
   end

   // Channel readies come from flops
   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // Write response
   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= AXI_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         if (awAddr == ADCC_CTL0_OFS || awAddr == ADCC_CTL1_OFS ||
             awAddr == ADCC_DATAH_OFS || awAddr == ADCC_DATAL_OFS) begin
            s_axi_bresp <= AXI_OKAY;
         end else begin
            s_axi_bresp <= AXI_SLVERR;   // Unmapped
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control register 0, all fields in one write
   always_ff @(posedge clk) begin
      if (reset) begin
         inputChannelSelect <= 4'h0;
         repeatConvert      <= 1'b0;
         vrefPinOutput      <= 1'b0;
         vrefLevelSel[0]    <= 1'b0;
      end else if (ctl0Write) begin
         inputChannelSelect <= wData[CTL0_CHAN_LSB +: 4];
         repeatConvert      <= wData[CTL0_REPEAT_BIT];
         vrefPinOutput      <= wData[CTL0_VPIN_BIT];
         vrefLevelSel[0]    <= wData[CTL0_VLO_BIT];
      end
   end

   // Control/status register 1 writable fields
   always_ff @(posedge clk) begin
      if (reset) begin
         inputBufferSelect <= 3'h0;
         vrefLevelSel[1]   <= 1'b0;
      end else if (doWrite && awAddr == ADCC_CTL1_OFS && wStrb[0]) begin
         inputBufferSelect <= wData[CTL1_BUF_LSB +: 3];
         vrefLevelSel[1]   <= wData[CTL1_VHI_BIT];
      end
   end

   // Conversion enable: set by software, cleared at first result
   always_ff @(posedge clk) begin
      if (reset) begin
         convertGo <= 1'b0;
      end else if (state == ST_FIRST && phaseEnd) begin
         convertGo <= 1'b0;
      end else if (ctl0Write) begin
         convertGo <= wData[CTL0_GO_BIT];
      end
   end

   // Conversion sequencer
   always_ff @(posedge clk) begin
      if (reset) begin
         state       <= ST_IDLE;
         cycleCnt    <= '0;
         corePowerOn <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (convertGo) begin
                  corePowerOn <= 1'b1;
                  if (corePowerOn) begin
                     state    <= ST_FIRST;
                     cycleCnt <= CW'(FIRST_CYC - 1);
                  end else begin
                     state    <= ST_PWRUP;
                     cycleCnt <= CW'(PWR_CYC - 1);
                  end
               end else begin
                  corePowerOn <= 1'b0;   // Power down when idle
               end
            end
            ST_PWRUP: begin
               if (phaseEnd) begin
                  state    <= ST_FIRST;
                  cycleCnt <= CW'(FIRST_CYC - 1);
               end else begin
                  cycleCnt <= cycleCnt - 1'b1;
               end
            end
            ST_FIRST, ST_REPEAT: begin
               if (phaseEnd) begin
                  if (repeatConvert) begin
                     state    <= ST_REPEAT;
                     cycleCnt <= CW'(REP_CYC - 1);
                  end else begin
                     state <= ST_IDLE;
                  end
               end else begin
                  cycleCnt <= cycleCnt - 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Result capture, both halves in one cycle
   // Raw signed word kept as is; software compensates offset then gain
   // Readback keeps all 13 bits, sign first, so no resolution is dropped here
   always_ff @(posedge clk) begin
      if (reset) begin
         resultUpperByte    <= 8'h00;
         resultLowerBits    <= 5'h00;
         sampleOverflowFlag <= 1'b0;
      end else if (resultDone) begin
         resultUpperByte    <= coreResult[RES_W-1 -: 8];
         resultLowerBits    <= coreResult[4:0];
         sampleOverflowFlag <= coreOverflow;
      end
   end

   // Completion pulses to interrupt controller and core
   always_ff @(posedge clk) begin
      if (reset) begin
         convDoneIrq  <= 1'b0;
         sampleStrobe <= 1'b0;
      end else begin
         convDoneIrq  <= resultDone;
         sampleStrobe <= resultDone;
      end
   end

   // Read channel
   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= AXI_OKAY;
      end else if (s_axi_rvalid) begin
         s_axi_arready <= 1'b0;
         if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= AXI_OKAY;
         s_axi_rdata   <= 32'h0;
         case (s_axi_araddr)
            ADCC_CTL0_OFS: begin
               s_axi_rdata[CTL0_CHAN_LSB +: 4] <= inputChannelSelect;
               s_axi_rdata[CTL0_REPEAT_BIT]    <= repeatConvert;
               s_axi_rdata[CTL0_VPIN_BIT]      <= vrefPinOutput;
               s_axi_rdata[CTL0_VLO_BIT]       <= vrefLevelSel[0];
               s_axi_rdata[CTL0_GO_BIT]        <= convertGo;
            end
            ADCC_CTL1_OFS: begin
               s_axi_rdata[CTL1_OVF_BIT]       <= sampleOverflowFlag;
               s_axi_rdata[CTL1_BUF_LSB +: 3]  <= inputBufferSelect;
               s_axi_rdata[CTL1_PWR_BIT]       <= corePowerOn;
               s_axi_rdata[CTL1_VHI_BIT]       <= vrefLevelSel[1];
            end
            ADCC_DATAH_OFS: begin
               s_axi_rdata[7:0] <= resultUpperByte;
            end
            ADCC_DATAL_OFS: begin
               s_axi_rdata[7:RES_LOW_LSB] <= resultLowerBits;
            end
            default: begin
               s_axi_rresp <= AXI_SLVERR;   // Unmapped
            end
         endcase
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule

/* File: adcc_pkg.sv */
package adcc_pkg;
   // Register byte offsets
   localparam logic [7:0] ADCC_CTL0_OFS    = 8'h00;   // Control register 0
   localparam logic [7:0] ADCC_CTL1_OFS    = 8'h04;   // Control/status register 1
   localparam logic [7:0] ADCC_DATAH_OFS   = 8'h08;   // Result upper byte
   localparam logic [7:0] ADCC_DATAL_OFS   = 8'h0c;   // Result lower bits
   // Control register 0 fields
   localparam int CTL0_CHAN_LSB   = 0;                // Input channel select [3:0]
   localparam int CTL0_REPEAT_BIT = 4;                // Continuous conversion
   localparam int CTL0_VPIN_BIT   = 5;                // Reference to pin
   localparam int CTL0_VLO_BIT    = 6;                // Reference select low bit
   localparam int CTL0_GO_BIT     = 7;                // Conversion enable
   // Control/status register 1 fields
   localparam int CTL1_OVF_BIT    = 0;                // Sample overflow flag
   localparam int CTL1_BUF_LSB    = 1;                // Input buffer select [3:1]
   localparam int CTL1_VHI_BIT    = 7;                // Reference select high bit
   localparam int CTL1_PWR_BIT    = 6;                // Analog core powered (read)
   // Result layout
   localparam int RES_W           = 13;               // Result width
   localparam int RES_LOW_LSB     = 3;                // Lower bits position
   // Timing in system clock cycles
   localparam int FIRST_CONV_CYC  = 5129;             // First conversion
   localparam int PWRUP_CYC       = 40;               // Power-up extra
   localparam int REPEAT_CYC      = 256;              // Later conversions
   // AXI responses
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   typedef enum {ST_IDLE, ST_PWRUP, ST_FIRST, ST_REPEAT} adcc_state_t;
endpackage

/* File: adcc_ctrl_monitor.sv */
`timescale 1ns/100ps
module adcc_ctrl_monitor
   import adcc_pkg::*;
#(
   parameter int FIRST_CYC = 20,
   parameter int PWR_CYC   = 4,
   parameter int REP_CYC   = 16
) (
   input logic        clk,
   input logic        reset,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic        corePowerOn,
   input logic        sampleStrobe,
   input logic        convDoneIrq
);
   int   gap;   // Cycles since last request
   logic seen;  // A request already seen this run
   // Request spacing, restarted whenever the core is off
   always_ff @(posedge clk) begin
      if (reset || !corePowerOn) begin
         gap  <= 0;
         seen <= 1'h0;
      end else if (convDoneIrq) begin
         gap  <= 1;
         seen <= 1'h1;
      end else begin
         gap <= gap + 1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Both write halves taken at one edge
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid) else $error("read answer late");
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   a_irq_strobe_pair: assert property (convDoneIrq == sampleStrobe) else $error("irq unpaired");
   a_irq_one_cycle: assert property (convDoneIrq |=> !convDoneIrq) else $error("irq too long");
   a_repeat_gap: assert property (convDoneIrq && seen |-> gap == REP_CYC) else $error("bad gap");
   a_no_irq_off: assert property (!$past(corePowerOn) |-> !convDoneIrq) else $error("irq off");
   a_first_wait: assert property ($rose(corePowerOn) |-> !convDoneIrq [*8]) else $error("early");
endmodule
bind adcc_ctrl adcc_ctrl_monitor #(.FIRST_CYC(FIRST_CYC), .PWR_CYC(PWR_CYC), .REP_CYC(REP_CYC))
   u_mon (.clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .corePowerOn, .sampleStrobe, .convDoneIrq);

/* File: adcc_core_model.sv */
`timescale 1ns/100ps
module adcc_core_model
   import adcc_pkg::*;
(
   input  logic             clk,
   input  logic             corePowerOn,
   input  logic             sampleStrobe,
   output logic [RES_W-1:0] coreResult,
   output logic             coreOverflow
);
   int seed = 2718;  // Fixed seed for sample values
   initial begin
      coreResult   = 13'h0;
      coreOverflow = 1'h0;
   end
   // Unpowered core wanders; powered core holds until captured
   always @(posedge clk) begin
      if (!corePowerOn) begin
         coreResult   <= ~coreResult;
         coreOverflow <= ~coreOverflow;
      end else if (sampleStrobe) begin
         coreResult   <= RES_W'($random(seed));
         coreOverflow <= 1'($random(seed));
      end
   end
endmodule

/* File: adc_continuous_conversion_ctrl_tb_top.sv */
`timescale 1ns/100ps
module adc_continuous_conversion_ctrl_tb_top
   import adcc_pkg::*;
;
   localparam int F = 20, P = 4, R = 24;  // Shortened counts
   logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, coreOverflow;
   logic vrefPinOutput, corePowerOn, sampleStrobe, convDoneIrq, expOvf;
   logic [7:0]       s_axi_awaddr, s_axi_araddr, c0;
   logic [31:0]      s_axi_wdata, s_axi_rdata, d, v, h;
   logic [3:0]       s_axi_wstrb, inputChannelSelect;
   logic [2:0]       inputBufferSelect;
   logic [1:0]       s_axi_bresp, s_axi_rresp, vrefLevelSel, r;
   logic [RES_W-1:0] coreResult, expRes;
   int               nFail, numChecks, seed, cyc, nIrq, irqCyc, t, n;
   adcc_ctrl #(.FIRST_CYC(F), .PWR_CYC(P), .REP_CYC(R)) dut (.clk, .reset, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .coreResult, .coreOverflow,
      .inputChannelSelect, .inputBufferSelect, .vrefLevelSel, .vrefPinOutput, .corePowerOn,
      .sampleStrobe, .convDoneIrq);
   adcc_core_model core (.clk, .corePowerOn, .sampleStrobe, .coreResult, .coreOverflow);
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         nFail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (nFail == 0 && numChecks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Bus write; response accepted a cycle late to exercise holding
   task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
      logic pa, pw;
      pa = 1'h1;
      pw = 1'h1;
      s_axi_awaddr <= a;
      s_axi_wdata <= dat;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (pa || pw) begin
         @(negedge clk);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         @(posedge clk);
         if (!pa) s_axi_awvalid <= 1'h0;
         if (!pw) s_axi_wvalid <= 1'h0;
      end
      do @(negedge clk); while (!s_axi_bvalid);
      @(posedge clk) s_axi_bready <= 1'h1;
      @(negedge clk) chk(s_axi_bresp, er);
      @(posedge clk) s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rr);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(negedge clk); while (!s_axi_arready);
      @(posedge clk) s_axi_arvalid <= 1'h0;
      do @(negedge clk); while (!s_axi_rvalid);
      @(posedge clk) s_axi_rready <= 1'h1;
      @(negedge clk);
      dat = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk) s_axi_rready <= 1'h0;
   endtask
   // Expected readback of the upper result byte
   function automatic logic [31:0] upperWord(input logic [RES_W-1:0] res);
      return {24'h0, res[RES_W-1 -: 8]};
   endfunction
   // Expected readback of the lower result bits
   function automatic logic [31:0] lowerWord(input logic [RES_W-1:0] res);
      return {24'h0, res[4:0], 3'h0};
   endfunction
   // Gain scaling by 8/7, product first so the remainder is not lost
   function automatic int scaled(input logic [RES_W-1:0] res);
      return ($signed(res) * 8) / 7;
   endfunction
   // Cycle count, timeout, capture of each sampled result
   always @(negedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         nFail++;
         summarize();
      end
      if (sampleStrobe) begin
         expRes = coreResult;
         expOvf = coreOverflow;
      end
      if (convDoneIrq) begin
         nIrq++;
         irqCyc = cyc;
      end
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      reset = 1'h1;
      seed = 96513;
      repeat (16) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         rd(8'(4 * i), d, r);
         chk(d, 32'h0);
      end
      rd(8'h10, d, r);
      chk(r, AXI_SLVERR);
      wr(8'h14, 32'h0, AXI_SLVERR);
      for (int k = 0; k < 6; k++) begin
         v = (k == 0) ? 32'hffffffff : $random(seed);
         wr(ADCC_CTL1_OFS, {24'h0, v[7], 3'h0, v[2:0], 1'h0}, AXI_OKAY);
         c0 = {2'h0, v[5] & |v[7:6], 1'h0, v[11:8]} | (8'(v[6]) << 6);
         wr(ADCC_CTL0_OFS, {24'h0, c0}, AXI_OKAY);
         chk(inputChannelSelect, v[11:8]);
         chk(inputBufferSelect, v[2:0]);
         chk(vrefLevelSel, v[7:6]);
         chk(vrefPinOutput, c0[5]);
         rd(ADCC_CTL0_OFS, d, r);
         chk(d, {24'h0, c0});
      end
      c0 = c0 | 8'h90;
      wr(ADCC_CTL0_OFS, {24'h0, c0}, AXI_OKAY);
      t = cyc;
      for (int j = 0; j < 200 && nIrq == 0; j++) @(posedge clk);
      chk(32'(irqCyc - t >= P + F && irqCyc - t <= P + F + 3), 32'h1);
      rd(ADCC_CTL0_OFS, d, r);
      chk(d, {24'h0, c0 & 8'h7f});
      for (int k = 0; k < 4; k++) begin
         n = nIrq;
         t = irqCyc;
         if (k > 0) for (int j = 0; j < 100 && nIrq == n; j++) @(posedge clk);
         if (k > 0) chk(irqCyc - t, R);
         rd(ADCC_DATAH_OFS, h, r);
         chk(h, upperWord(expRes));
         rd(ADCC_DATAL_OFS, d, r);
         chk(d & 32'hf8, lowerWord(expRes));
         chk(32'(scaled({h[7:0], d[7:3]})), 32'(scaled(expRes)));
         rd(ADCC_CTL1_OFS, d, r);
         chk(d & 32'h41, 32'h40 | 32'(expOvf));
      end
      wr(ADCC_CTL0_OFS, {24'h0, c0 & 8'h6f}, AXI_OKAY);
      n = nIrq;
      repeat (3 * R) @(posedge clk);
      chk(nIrq, n + 1);
      chk(corePowerOn, 1'h0);
      summarize();
   end
endmodule
